/* File: vfd_pin_map.vh */
`ifndef VFD_PIN_MAP_VH
`define VFD_PIN_MAP_VH

// Register addresses on the plain register port
`define ADDR_SEG_CTRL 2'h0
`define ADDR_DIG_CTRL 2'h1
`define ADDR_DUAL_SW 2'h2

// Reset values
`define SEG_CTRL_RST 8'h20
`define DIG_CTRL_RST 8'h00
`define DUAL_SW_RST 8'h20

// Segment control fields
`define SEG_SWITCH_BIT 7
`define SEG_KEYSCAN_BIT 6
`define SEG_FIXED_BIT 5
`define SEG_COUNT_MSB 4

// Digit control fields
`define DIG_MODE_BIT 7
`define DIG_WAVE_MSB 6
`define DIG_WAVE_LSB 4
`define DIG_COUNT_MSB 3

// Dual-pin switch fields
`define DUAL_FIXED_BIT 5
`define DUAL_SPLIT_MSB 3

// Timing in system clocks
`define DIGIT_CLKS 1536
`define DIMMER_CLKS 96

`endif

/* File: vfd_slot_timer.v */
`timescale 1ns/1ns
// Digit-time and dimmer-step generator; half length when fast mode set
module vfd_slot_timer #(
  parameter DIGIT_CLKS = 1536,
  parameter DIMMER_CLKS = 96
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire fast_mode,
  // Timing outputs
  output reg slot_end,
  output reg [3:0] step_q
);

  reg [10:0] cnt_q;
  reg [6:0] step_cnt_q;
  wire [10:0] digit_last;
  wire [6:0] step_last;

  assign digit_last = fast_mode ? 11'd767 : 11'd1535;
  assign step_last = fast_mode ? 7'd47 : 7'd95;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 11'h000;
      step_cnt_q <= 7'h00;
      step_q <= 4'h0;
      slot_end <= 1'b0;
    end
    else
    begin
      slot_end <= (cnt_q == digit_last - 11'd1);
      if (cnt_q >= digit_last)
      begin
        cnt_q <= 11'h000;
        step_cnt_q <= 7'h00;
        step_q <= 4'h0;
      end
      else
      begin
        cnt_q <= cnt_q + 11'd1;
        if (step_cnt_q >= step_last)
        begin
          step_cnt_q <= 7'h00;
          step_q <= step_q + 4'd1;
        end
        else
          step_cnt_q <= step_cnt_q + 7'd1;
      end
    end
  end

endmodule // vfd_slot_timer

/* File: vfd_pin_select_control.v */
`timescale 1ns/1ns
`include "vfd_pin_map.vh"

// Summary of operation
// - Three-bit field selects digit waveform shape
// - Digit code n enables digits 0..15-n
// - Digit code with dual split picks pins
// - Segment control eight bits, resets to 20
// - Segment control bit five reads one always
// - Switch flag zero makes all pins ports
// - Switch flag one enables configured display pins
// - Key scan: segments ports, flag reads zero
// - Key-scan enable zero adds no slot
// - Key-scan enable one appends one digit slot
// - Segment code n enables segments 0..n
// - Segment code with dual split picks pins
// - Mode bit: 1536/96 clocks or half
// - Frame is digits plus optional key slot
// - Key slot holds display pins pulled down
// - Dual code k: k segments, bit3 all
module vfd_pin_select_control #(
  parameter DIGIT_CLKS = `DIGIT_CLKS,
  parameter DIMMER_CLKS = `DIMMER_CLKS
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Display pins
  output reg [15:0] digit_strobe_pin,
  output reg [23:0] segment_drive_pin,
  output reg [15:0] digit_is_display,
  output reg [23:0] segment_is_display,
  output reg keyscan_active,
  output reg [3:0] digit_index
);

  reg [7:0] segment_control_q;
  reg [7:0] digit_control_q;
  reg [7:0] dual_pin_switch_reg_q;
  reg [3:0] scan_q;
  reg keyscan_q;
  wire slot_end;
  wire [3:0] step;

  wire port_display_switch = segment_control_q[`SEG_SWITCH_BIT];
  wire keyscan_slot_enable = segment_control_q[`SEG_KEYSCAN_BIT];
  wire [4:0] segment_count_code = segment_control_q[`SEG_COUNT_MSB:0];
  wire [2:0] digit_waveform_sel =
    digit_control_q[`DIG_WAVE_MSB:`DIG_WAVE_LSB];
  wire [3:0] digit_count_code = digit_control_q[`DIG_COUNT_MSB:0];
  wire [3:0] dual_pin_split = dual_pin_switch_reg_q[`DUAL_SPLIT_MSB:0];
  wire digit_time_mode = digit_control_q[`DIG_MODE_BIT];
  wire [3:0] last_digit = 4'hf - digit_count_code;

  // Number of shared pins given to segments
  wire [3:0] seg_share = dual_pin_split[3] ? 4'd8 :
    {1'b0, dual_pin_split[2:0]};

  reg [15:0] dig_en;
  reg [23:0] seg_en;
  reg lit;
  integer i;

  // Dual pins: digit i (0..7) is shared with segment 7-i.
  always @*
  begin
    dig_en = 16'h0000;
    seg_en = 24'h000000;
    for (i = 0; i < 16; i = i + 1)
      dig_en[i] = (i[3:0] <= last_digit) &&
        !(i < 8 && i[3:0] < seg_share);
    for (i = 0; i < 24; i = i + 1)
      seg_en[i] = ((i[4:0] <= segment_count_code) ||
        (segment_count_code > 5'd23)) &&
        !(i < 8 && (4'd7 - i[3:0]) >= seg_share);
  end

  // Lit steps within a digit; codes defined here
  always @*
  begin
    case (digit_waveform_sel)
      3'h0: lit = (step < 4'd15);
      3'h1: lit = (step < 4'd14);
      3'h2: lit = (step < 4'd12);
      3'h3: lit = (step < 4'd10);
      3'h4: lit = (step < 4'd8);
      3'h5: lit = (step < 4'd6);
      3'h6: lit = (step < 4'd4);
      3'h7: lit = (step < 4'd2);
      default: lit = 1'b0;
    endcase
  end

  vfd_slot_timer #(
    .DIGIT_CLKS(DIGIT_CLKS),
    .DIMMER_CLKS(DIMMER_CLKS)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .fast_mode(digit_time_mode),
    .slot_end(slot_end),
    .step_q(step)
  );

  // Register writes
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      segment_control_q <= `SEG_CTRL_RST;
      digit_control_q <= `DIG_CTRL_RST;
      dual_pin_switch_reg_q <= `DUAL_SW_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_SEG_CTRL:
          segment_control_q <= reg_wdata | 8'h20;
        `ADDR_DIG_CTRL:
          digit_control_q <= reg_wdata;
        `ADDR_DUAL_SW:
          dual_pin_switch_reg_q <= reg_wdata | 8'h20;
        default:
          digit_control_q <= digit_control_q;
      endcase
    end
  end

  // Frame sequencer: digits 0..last then optional key slot
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_q <= 4'h0;
      keyscan_q <= 1'b0;
    end
    else if (slot_end)
    begin
      if (keyscan_q || scan_q >= last_digit)
      begin
        if (!keyscan_q && keyscan_slot_enable)
          keyscan_q <= 1'b1;
        else
        begin
          keyscan_q <= 1'b0;
          scan_q <= 4'h0;
        end
      end
      else
        scan_q <= scan_q + 4'd1;
    end
  end

  // Pin outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      digit_strobe_pin <= 16'h0000;
      segment_drive_pin <= 24'h000000;
      digit_is_display <= 16'h0000;
      segment_is_display <= 24'h000000;
      keyscan_active <= 1'b0;
      digit_index <= 4'h0;
    end
    else
    begin
      keyscan_active <= keyscan_q;
      digit_index <= scan_q;
      if (!port_display_switch || keyscan_q)
      begin
        // Ports during key slot; drivers pulled down
        digit_is_display <= 16'h0000;
        segment_is_display <= 24'h000000;
        digit_strobe_pin <= 16'h0000;
        segment_drive_pin <= 24'h000000;
      end
      else
      begin
        digit_is_display <= dig_en;
        segment_is_display <= seg_en;
        digit_strobe_pin <= (dig_en & (16'h0001 << scan_q)) &
          {16{lit}};
        segment_drive_pin <= seg_en;
      end
    end
  end

  // Read data one cycle after strobe
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_SEG_CTRL:
          reg_rdata <= {port_display_switch & ~keyscan_q,
            segment_control_q[6:0]};
        `ADDR_DIG_CTRL:
          reg_rdata <= digit_control_q;
        `ADDR_DUAL_SW:
          reg_rdata <= dual_pin_switch_reg_q;
        default:
          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule // vfd_pin_select_control

/* File: vfd_pin_select_control_checker.sv */
`timescale 1ns/1ns
module vfd_pin_select_control_checker #(
  parameter DIGIT_CLKS = 1536
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [1:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Display pins
  input wire [15:0] digit_strobe_pin,
  input wire [23:0] segment_drive_pin,
  input wire [15:0] digit_is_display,
  input wire [23:0] segment_is_display,
  input wire keyscan_active
);
  reg [11:0] ks_q;
  // Length of the running key slot
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      ks_q <= 12'h000;
    else
      ks_q <= keyscan_active ? ks_q + 12'h001 : 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_seg_bit_five: assert property ($past(reg_rd) &&
    $past(reg_addr) == 2'h0 |-> reg_rdata[5]) else $error("bit5 low");
  chk_unmapped_reads_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) == 2'h3 |-> reg_rdata == 8'h00) else $error("unmapped");
  chk_flag_in_scan: assert property ($past(reg_rd) &&
    $past(reg_addr) == 2'h0 && $past(keyscan_active) && keyscan_active
    |-> !reg_rdata[7]) else $error("flag in scan");
  chk_scan_seg_port: assert property ($past(keyscan_active) &&
    keyscan_active |-> segment_is_display == 24'h0) else $error("seg");
  chk_scan_pins_dark: assert property ($past(keyscan_active) &&
    keyscan_active |-> digit_strobe_pin == 16'h0 &&
    segment_drive_pin == 24'h0) else $error("lit in scan");
  chk_strobe_one_hot: assert property (
    $onehot0(digit_strobe_pin)) else $error("two strobes");
  chk_strobe_on_digit: assert property ($stable(digit_is_display)
    |-> (digit_strobe_pin & ~digit_is_display) == 16'h0) else $error("stb");
  chk_drive_on_seg: assert property ($stable(segment_is_display)
    |-> (segment_drive_pin & ~segment_is_display) == 24'h0) else $error("sg");
  chk_slot_length: assert property ($fell(keyscan_active)
    |-> ks_q == DIGIT_CLKS || ks_q == DIGIT_CLKS / 2) else $error("slot");
  cover property ($rose(keyscan_active));
  cover property ($past(reg_rd) && $past(reg_addr) == 2'h0);
  cover property (digit_strobe_pin != 16'h0);
endmodule // vfd_pin_select_control_checker

/* File: vfd_glass_model.sv */
`timescale 1ns/1ns
// Passive glass: measures lit and dark intervals, never drives back
module vfd_glass_model (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Electrodes
  input wire strobe0,
  input wire keyscan_active,
  // Measurements
  output reg [11:0] dark_len,
  output reg [15:0] period,
  output reg [11:0] lit_len,
  output reg [7:0] dark_cnt
);
  reg [11:0] d_q;
  reg [15:0] p_q;
  reg [11:0] l_q;
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      {d_q, p_q, l_q, dark_len, period, lit_len, dark_cnt} <= 0;
    end
    else
    begin
      d_q <= keyscan_active ? d_q + 12'h001 : 12'h000;
      if (!keyscan_active && d_q != 12'h000)
        dark_len <= d_q;
      p_q <= (keyscan_active && d_q == 12'h000) ? 16'h0001 : p_q + 16'h0001;
      if (keyscan_active && d_q == 12'h000)
      begin
        period <= p_q;
        dark_cnt <= dark_cnt + 8'h01;
      end
      l_q <= strobe0 ? l_q + 12'h001 : 12'h000;
      if (!strobe0 && l_q != 12'h000)
        lit_len <= l_q;
    end
endmodule // vfd_glass_model

/* File: vfd_pin_select_control_tb.sv */
`timescale 1ns/1ns
`define CK(n, e, s) begin n_checks = n_checks + 1; if ((s) !== (e)) \
  begin err_count = err_count + 1; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module vfd_pin_select_control_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [1:0] reg_addr = 2'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] d;
  wire [7:0] reg_rdata;
  wire [15:0] digit_strobe_pin, digit_is_display, period;
  wire [23:0] segment_drive_pin, segment_is_display;
  wire keyscan_active;
  wire [3:0] digit_index;
  wire [11:0] dark_len, lit_len;
  wire [7:0] dark_cnt;
  integer err_count = 0, n_checks = 0, m, c;
  always #2 clk = ~clk;
  vfd_pin_select_control i_vfd_pin_select_control (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .digit_strobe_pin(digit_strobe_pin), .digit_index(digit_index),
    .segment_drive_pin(segment_drive_pin), .keyscan_active(keyscan_active),
    .digit_is_display(digit_is_display),
    .segment_is_display(segment_is_display));
  vfd_glass_model i_vfd_glass_model (.clk(clk), .rst_b(rst_b),
    .strobe0(digit_strobe_pin[0]), .keyscan_active(keyscan_active),
    .dark_len(dark_len), .period(period), .lit_len(lit_len),
    .dark_cnt(dark_cnt));
  task wr(input [1:0] a, input [7:0] v);
  begin
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [1:0] a);
  begin
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  task pins(input [7:0] du, dg, sg, input [15:0] ed, input [23:0] es);
  begin
    wr(2'h2, du);
    wr(2'h1, dg);
    wr(2'h0, sg);
    repeat (3) @(posedge clk);
    #1 `CK("digits", ed, digit_is_display)
    `CK("segments", es, segment_is_display)
    // Key scan is off here, so enabled segments are driven
    `CK("drive", es, segment_drive_pin)
  end
  endtask
  task give_verdict;
  begin
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Span covers the waveform sweep and both key-scan passes
  initial
  begin
    #400000 err_count = err_count + 1;
    give_verdict;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(2'h0); `CK("seg_rst", 8'h20, d)
    rd(2'h1); `CK("dig_rst", 8'h00, d)
    rd(2'h2); `CK("dual_rst", 8'h20, d)
    wr(2'h3, 8'hff); rd(2'h3); `CK("unmapped", 8'h00, d)
    pins(8'h00, 8'h00, 8'h17, 16'h0000, 24'h000000);
    rd(2'h0); `CK("seg_bit5", 8'h37, d)
    pins(8'h00, 8'h00, 8'h97, 16'hffff, 24'hffff00);
    pins(8'h08, 8'h00, 8'h97, 16'hff00, 24'hffffff);
    pins(8'h03, 8'h04, 8'h85, 16'h0ff8, 24'h000020);
    pins(8'h00, 8'h0f, 8'h80, 16'h0001, 24'h000000);
    for (m = 0; m < 8; m = m + 1)
    begin
      wr(2'h1, {1'b0, m[2:0], 4'hf});
      repeat (3200) @(posedge clk);
      `CK("index", 4'h0, digit_index)
      `CK("lit", (m == 0 ? 15 : 16 - 2 * m) * 96, lit_len)
    end
    for (m = 0; m < 2; m = m + 1)
    begin
      // Key scan is switched off between slots so no slot is cut short
      while (keyscan_active === 1'b1) @(posedge clk);
      wr(2'h0, 8'h80);
      repeat (1600) @(posedge clk);
      c = dark_cnt;
      repeat (3200) @(posedge clk);
      `CK("no_slot", c, dark_cnt)
      wr(2'h1, {m[0], 7'h0f});
      wr(2'h0, 8'hc0);
      for (c = 0; c < 4000 && keyscan_active !== 1'b1; c = c + 1)
        @(posedge clk);
      rd(2'h0); `CK("flag", 8'h60, d)
      repeat (6 * (1536 >> m)) @(posedge clk);
      `CK("slot", 1536 >> m, dark_len)
      `CK("frame", 2 * (1536 >> m), period)
    end
    give_verdict;
  end
endmodule // vfd_pin_select_control_tb
bind vfd_pin_select_control vfd_pin_select_control_checker #(
  .DIGIT_CLKS(DIGIT_CLKS)) i_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .digit_strobe_pin(digit_strobe_pin), .keyscan_active(keyscan_active),
  .segment_drive_pin(segment_drive_pin),
  .digit_is_display(digit_is_display),
  .segment_is_display(segment_is_display));
